// file: fpx_exc_unit.v
// floating-point exception condition unit
`timescale 1ns/1ps
`default_nettype none
`include "fpx_map.vh"
module fpx_exc_unit (
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire        op_valid_i,     // one operation completes
  input  wire [3:0]  op_kind_i,      // operation code
  input  wire        single_prec_i,  // single target precision
  input  wire [63:0] op_a_i,         // operand a
  input  wire [63:0] op_b_i,         // operand b
  input  wire [63:0] op_c_i,         // operand c (multiply, multiply-add)
  input  wire [3:0]  cmp_code_i,     // ordered compare code
  input  wire        pre_zero_i,     // intermediate is zero
  input  wire [12:0] pre_exp_i,      // exponent before rounding
  input  wire        rnd_sign_i,     // intermediate sign
  input  wire [12:0] rnd_exp_i,      // rounded, unbounded exponent
  input  wire [51:0] rnd_frac_i,     // rounded fraction
  input  wire        rnd_up_i,       // rounding incremented
  input  wire        rnd_inexact_i,  // rounding changed value
  input  wire [63:0] den_result_i,   // denormalized rounded value
  input  wire        den_up_i,       // denormal rounding incremented
  input  wire        den_inexact_i,  // denormal lost accuracy
  input  wire [63:0] int_result_i,   // integer convert result
  input  wire        int_inexact_i,  // convert rounding inexact
  input  wire        sw_wr_i,        // status word write
  input  wire [31:0] sw_wdata_i,     // status word value
  input  wire        sw_setbit_i,    // set single status bit
  input  wire [4:0]  sw_bit_i,       // bit to set
  output reg  [31:0] float_status_control_reg_o,
  output reg         dest_wr_o,      // destination write pulse
  output reg  [63:0] dest_float_reg_o
);
  ////////////////////////////////////////////////////////////
  // result helpers
  // pack sign, unbiased exponent and fraction
  function [63:0] pack;
    input        s;
    input [12:0] e;
    input [51:0] f;
    reg   [12:0] be;
    begin
      be   = e + `FPX_BIAS;
      pack = {s, be[10:0], f};
    end
  endfunction

  // largest finite magnitude of target precision
  function [63:0] maxfin;
    input s;
    input sp;
    begin
      if (sp) begin
        maxfin = pack(s, `FPX_EMAX_S, {23'h7F_FFFF, 29'h0});
      end else begin
        maxfin = {s, 11'h7FE, 52'hF_FFFF_FFFF_FFFF};
      end
    end
  endfunction

  // signed infinity
  function [63:0] infv;
    input s;
    begin
      infv = {s, 11'h7FF, 52'h0};
    end
  endfunction

  // class code of a written value
  function [4:0] cls_of;
    input [63:0] v;
    input        sp;
    reg   [10:0] e;
    begin
      e = v[62:52];
      if (e == 11'h7FF) begin
        if (|v[51:0]) begin
          cls_of = `FPX_C_QNAN;
        end else begin
          cls_of = v[63] ? `FPX_C_NINF : `FPX_C_PINF;
        end
      end else if (v[62:0] == 63'h0) begin
        cls_of = v[63] ? `FPX_C_NZERO : `FPX_C_PZERO;
      end else if (e == 11'h000 || (sp && e < `FPX_SDEN_EXP)) begin
        cls_of = v[63] ? `FPX_C_NDEN : `FPX_C_PDEN;
      end else begin
        cls_of = v[63] ? `FPX_C_NNORM : `FPX_C_PNORM;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // operand classification
  wire        sa;      // operand signs
  wire        sb;
  wire        sc;
  wire        na;      // NaN operands
  wire        nb;
  wire        nc;
  wire        sna;     // signaling NaN operands
  wire        snb;
  wire        snc;
  wire        ia;      // infinite operands
  wire        ib;
  wire        ic;
  wire        za;      // zero operands
  wire        zb;
  wire        zc;
  wire [12:0] eb;      // convert source exponent
  reg  [31:0] st_r;    // status register

  fpx_opclass u_cls_a (
    .val_i  (op_a_i),
    .sign_o (sa),
    .nan_o  (na),
    .snan_o (sna),
    .inf_o  (ia),
    .zero_o (za),
    .exp_o  ()
  );
  fpx_opclass u_cls_b (
    .val_i  (op_b_i),
    .sign_o (sb),
    .nan_o  (nb),
    .snan_o (snb),
    .inf_o  (ib),
    .zero_o (zb),
    .exp_o  (eb)
  );
  fpx_opclass u_cls_c (
    .val_i  (op_c_i),
    .sign_o (sc),
    .nan_o  (nc),
    .snan_o (snc),
    .inf_o  (ic),
    .zero_o (zc),
    .exp_o  ()
  );

  ////////////////////////////////////////////////////////////
  // condition detection
  wire [3:0] k;          // operation kind
  wire       ve;         // trap enables
  wire       oe;
  wire       ue;
  wire       ze;
  wire       is_cmp;     // compare of either kind
  wire       is_cvt;     // integer convert
  wire       eff_sub;    // effective subtraction
  wire       prod_inf;   // multiply-add product infinite
  wire       c_snan;     // invalid causes
  wire       c_isi;
  wire       c_idi;
  wire       c_zdz;
  wire       c_imz;
  wire       c_vc;
  wire       c_sqrt;
  wire       c_cvi;
  wire       inv;        // any invalid cause
  wire       zdiv;       // zero divide
  wire       ovf;        // overflow
  wire       tiny;       // tiny before rounding
  wire       big32;      // convert magnitude too large
  wire       big64;

  assign k       = op_kind_i;
  assign ve      = st_r[`FPX_VE];
  assign oe      = st_r[`FPX_OE];
  assign ue      = st_r[`FPX_UE];
  assign ze      = st_r[`FPX_ZE];
  assign is_cmp  = (k == `FPX_OP_CMPU) | (k == `FPX_OP_CMPO);
  assign is_cvt  = (k == `FPX_OP_CVT32) | (k == `FPX_OP_CVT64);
  assign eff_sub = (k == `FPX_OP_MADD) ? (sa ^ sc ^ sb)
                                       : (sa ^ sb ^ (k == `FPX_OP_SUB));
  assign prod_inf = ia | ic;
  assign c_snan = (k != `FPX_OP_MOVE) & (sna | snb | snc);
  assign c_isi  = eff_sub & ia & ib &
                  ((k == `FPX_OP_ADD) | (k == `FPX_OP_SUB)) |
                  (k == `FPX_OP_MADD) & prod_inf & ib & eff_sub &
                  ~(za | zc);
  assign c_idi  = (k == `FPX_OP_DIV) & ia & ib;
  assign c_zdz  = (k == `FPX_OP_DIV) & za & zb;
  assign c_imz  = ((k == `FPX_OP_MUL) | (k == `FPX_OP_MADD)) &
                  (ia & zc | za & ic);
  assign c_vc   = (k == `FPX_OP_CMPO) & (na | nb);
  assign c_sqrt = ((k == `FPX_OP_SQRT) | (k == `FPX_OP_RSQRT)) &
                  sb & ~zb & ~nb;
  assign big32  = $signed(eb) >= $signed(13'd31) &
                  ~(sb & eb == 13'd31 & op_b_i[51:0] == 52'h0);
  assign big64  = $signed(eb) >= $signed(13'd63) &
                  ~(sb & eb == 13'd63 & op_b_i[51:0] == 52'h0);
  assign c_cvi  = is_cvt & (nb | ib |
                  ((k == `FPX_OP_CVT32) ? big32 : big64));
  assign inv    = c_snan | c_isi | c_idi | c_zdz | c_imz | c_vc |
                  c_sqrt | c_cvi;
  assign zdiv   = (k == `FPX_OP_DIV) & zb & ~nb & ~za & ~ia & ~na;
  // rounded unbounded exponent above format maximum
  assign ovf    = $signed(rnd_exp_i) >
                  $signed(single_prec_i ? `FPX_EMAX_S : `FPX_EMAX_D);
  assign tiny   = ~pre_zero_i & ($signed(pre_exp_i) <
                  $signed(single_prec_i ? `FPX_EMIN_S : `FPX_EMIN_D));

  ////////////////////////////////////////////////////////////
  // result and status selection
  reg [31:0] base;     // status after software writes
  reg [31:0] hw_set;   // flags raised by the operation
  reg [31:0] nxt;      // final next status
  reg        fld_wr;   // operation updates FR FI class
  reg [4:0]  cls;      // class to store
  reg        fr;       // rounded-up to store
  reg        fi;       // inexact-fraction to store
  reg        wr_nxt;   // destination write
  reg [63:0] res_nxt;  // destination value
  reg [12:0] adj;      // trap exponent adjustment
  reg [63:0] ovres;    // disabled overflow value
  reg [63:0] rnd_val;  // normal rounded value

  always @* begin
    base    = st_r;
    hw_set  = 32'h0000_0000;
    fld_wr  = 1'b0;
    cls     = st_r[`FPX_CLS_LO +: 5];
    fr      = 1'b0;
    fi      = 1'b0;
    wr_nxt  = 1'b0;
    res_nxt = dest_float_reg_o;
    adj     = single_prec_i ? `FPX_ADJ_S : `FPX_ADJ_D;
    rnd_val = pack(rnd_sign_i, rnd_exp_i, rnd_frac_i);
    case (st_r[`FPX_RND_LO +: 2])
      2'd0: begin
        ovres = infv(rnd_sign_i);
      end
      2'd1: begin
        ovres = maxfin(rnd_sign_i, single_prec_i);
      end
      2'd2: begin
        ovres = rnd_sign_i ? maxfin(1'b1, single_prec_i) : infv(1'b0);
      end
      default: begin
        ovres = rnd_sign_i ? infv(1'b1) : maxfin(1'b0, single_prec_i);
      end
    endcase
    // software status writes and bit sets
    if (sw_wr_i) begin
      base = sw_wdata_i;
    end else if (sw_setbit_i) begin
      base[sw_bit_i] = 1'b1;
    end
    if (op_valid_i) begin
      hw_set[`FPX_INV_SIGNALING_NAN_FLAG] = c_snan;
      hw_set[`FPX_INV_INF_MINUS_INF_FLAG]  = c_isi;
      hw_set[`FPX_INV_INF_DIV_INF_FLAG]  = c_idi;
      hw_set[`FPX_INV_ZERO_DIV_ZERO_FLAG]  = c_zdz;
      hw_set[`FPX_INV_INF_TIMES_ZERO_FLAG]  = c_imz;
      hw_set[`FPX_INV_COMPARE_FLAG]   = c_vc;
      hw_set[`FPX_VXSQRT] = c_sqrt;
      hw_set[`FPX_INV_INT_CONVERT_FLAG]  = c_cvi;
      if (k == `FPX_OP_MOVE) begin
        // moves raise nothing
        fld_wr = 1'b0;
      end else if (is_cmp) begin
        base[`FPX_CC_LO +: 4] = (na | nb) ? `FPX_CC_UNORD : cmp_code_i;
      end else if (inv) begin
        fld_wr = 1'b1;
        if (ve) begin
          cls = st_r[`FPX_CLS_LO +: 5];
        end else if (k == `FPX_OP_CVT32) begin
          // most negative word in low half
          wr_nxt  = 1'b1;
          res_nxt = `FPX_INT32_MN;
        end else if (k == `FPX_OP_CVT64) begin
          wr_nxt  = 1'b1;
          res_nxt = `FPX_INT64_MN;
        end else begin
          wr_nxt  = 1'b1;
          res_nxt = `FPX_QNAN;
          cls     = `FPX_C_QNAN;
        end
      end else if (zdiv) begin
        // zero divide flag, FR FI cleared
        hw_set[`FPX_ZX] = 1'b1;
        fld_wr          = 1'b1;
        if (!ze) begin
          wr_nxt  = 1'b1;
          res_nxt = infv(sa ^ sb);
          cls     = (sa ^ sb) ? `FPX_C_NINF : `FPX_C_PINF;
        end
      end else if (is_cvt) begin
        // valid convert keeps the class field
        fld_wr            = 1'b1;
        wr_nxt            = 1'b1;
        res_nxt           = int_result_i;
        fi                = int_inexact_i;
        hw_set[`FPX_XX]   = int_inexact_i;
      end else if (ovf) begin
        hw_set[`FPX_OX] = 1'b1;
        fld_wr          = 1'b1;
        wr_nxt          = 1'b1;
        if (oe) begin
          res_nxt         = pack(rnd_sign_i, rnd_exp_i - adj, rnd_frac_i);
          cls             = rnd_sign_i ? `FPX_C_NNORM : `FPX_C_PNORM;
          fr              = rnd_up_i;
          fi              = rnd_inexact_i;
          hw_set[`FPX_XX] = rnd_inexact_i;
        end else begin
          hw_set[`FPX_XX] = 1'b1;
          res_nxt         = ovres;
          cls             = cls_of(ovres, single_prec_i);
        end
      end else if (tiny && ue) begin
        hw_set[`FPX_UX] = 1'b1;
        fld_wr          = 1'b1;
        wr_nxt          = 1'b1;
        res_nxt         = pack(rnd_sign_i, rnd_exp_i + adj, rnd_frac_i);
        cls             = rnd_sign_i ? `FPX_C_NNORM : `FPX_C_PNORM;
        // rounding flags kept for the handler
        fr              = rnd_up_i;
        fi              = rnd_inexact_i;
        hw_set[`FPX_XX] = rnd_inexact_i;
      end else if (tiny) begin
        hw_set[`FPX_UX] = den_inexact_i;
        hw_set[`FPX_XX] = den_inexact_i;
        fld_wr          = 1'b1;
        wr_nxt          = 1'b1;
        res_nxt         = den_result_i;
        cls             = cls_of(den_result_i, single_prec_i);
        fr              = den_up_i;
        fi              = den_inexact_i;
      end else begin
        hw_set[`FPX_XX] = rnd_inexact_i;
        fld_wr          = 1'b1;
        wr_nxt          = 1'b1;
        res_nxt         = pre_zero_i ? {rnd_sign_i, 63'h0} : rnd_val;
        cls             = cls_of(res_nxt, single_prec_i);
        fr              = rnd_up_i;
        fi              = rnd_inexact_i;
      end
    end
    // set wins over a simultaneous software clear
    nxt = base | hw_set;
    // operation result fields override a software write
    if (fld_wr) begin
      nxt[`FPX_CLS_LO +: 5] = cls;
      nxt[`FPX_FR]          = fr;
      nxt[`FPX_FI]          = fi;
    end
    // software-set request is an invalid condition
    nxt[`FPX_VX] = |(nxt & `FPX_INV_MASK);
    // summary on any rising condition flag
    nxt[`FPX_FX] = base[`FPX_FX] |
                   (|(nxt & ~st_r & `FPX_EXC_MASK));
    nxt[`FPX_FEX] = (nxt[`FPX_VX] & nxt[`FPX_VE]) |
                    (nxt[`FPX_OX] & nxt[`FPX_OE]) |
                    (nxt[`FPX_UX] & nxt[`FPX_UE]) |
                    (nxt[`FPX_ZX] & nxt[`FPX_ZE]) |
                    (nxt[`FPX_XX] & nxt[`FPX_XE]);
  end

  ////////////////////////////////////////////////////////////
  // state and output registers
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r                       <= `FPX_RESET;
      float_status_control_reg_o <= `FPX_RESET;
      dest_wr_o                  <= 1'b0;
      dest_float_reg_o           <= 64'h0000_0000_0000_0000;
    end else begin
      st_r                       <= nxt;
      float_status_control_reg_o <= nxt;
      dest_wr_o                  <= wr_nxt;
      dest_float_reg_o           <= res_nxt;
    end
  end
endmodule // fpx_exc_unit
`default_nettype wire

// file: fpx_map.vh
// constants of the floating-point exception condition unit
`ifndef FPX_MAP_VH
`define FPX_MAP_VH
// status register bit positions
`define FPX_RND_LO   0
`define FPX_XE       3
`define FPX_ZE       4
`define FPX_UE       5
`define FPX_OE       6
`define FPX_VE       7
`define FPX_INV_INT_CONVERT_FLAG    8
`define FPX_VXSQRT   9
`define FPX_INV_SOFTWARE_REQUEST_FLAG   10
`define FPX_CC_LO    12
`define FPX_CLS_LO   12
`define FPX_FI       17
`define FPX_FR       18
`define FPX_INV_COMPARE_FLAG     19
`define FPX_INV_INF_TIMES_ZERO_FLAG    20
`define FPX_INV_ZERO_DIV_ZERO_FLAG    21
`define FPX_INV_INF_DIV_INF_FLAG    22
`define FPX_INV_INF_MINUS_INF_FLAG    23
`define FPX_INV_SIGNALING_NAN_FLAG   24
`define FPX_XX       25
`define FPX_ZX       26
`define FPX_UX       27
`define FPX_OX       28
`define FPX_VX       29
`define FPX_FEX      30
`define FPX_FX       31
`define FPX_RESET    32'h0000_0000
`define FPX_EXC_MASK 32'h1FF8_0700
`define FPX_INV_MASK 32'h01F8_0700
// result class codes
`define FPX_C_QNAN   5'h11
`define FPX_C_NINF   5'h09
`define FPX_C_NNORM  5'h08
`define FPX_C_NDEN   5'h18
`define FPX_C_NZERO  5'h12
`define FPX_C_PZERO  5'h02
`define FPX_C_PDEN   5'h14
`define FPX_C_PNORM  5'h04
`define FPX_C_PINF   5'h05
`define FPX_CC_UNORD 4'h1
// operation codes
`define FPX_OP_MOVE  4'h0
`define FPX_OP_ADD   4'h1
`define FPX_OP_SUB   4'h2
`define FPX_OP_MUL   4'h3
`define FPX_OP_DIV   4'h4
`define FPX_OP_MADD  4'h5
`define FPX_OP_SQRT  4'h6
`define FPX_OP_RSQRT 4'h7
`define FPX_OP_CMPU  4'h8
`define FPX_OP_CMPO  4'h9
`define FPX_OP_CVT32 4'hA
`define FPX_OP_CVT64 4'hB
`define FPX_OP_FRSP  4'hC
// exponent limits and trap adjustments
`define FPX_BIAS     13'h03FF
`define FPX_EMAX_D   13'h03FF
`define FPX_EMAX_S   13'h007F
`define FPX_EMIN_D   13'h1C02
`define FPX_EMIN_S   13'h1F82
`define FPX_ADJ_D    13'h0600
`define FPX_ADJ_S    13'h00C0
`define FPX_QNAN     64'h7FF8_0000_0000_0000
`define FPX_INT32_MN 64'h0000_0000_8000_0000
`define FPX_INT64_MN 64'h8000_0000_0000_0000
`define FPX_SDEN_EXP 11'h381
`endif

// file: fpx_opclass.v
// operand classifier for double-format values
`timescale 1ns/1ps
`default_nettype none
`include "fpx_map.vh"
module fpx_opclass (
  input  wire [63:0] val_i,
  output wire        sign_o,
  output wire        nan_o,
  output wire        snan_o,
  output wire        inf_o,
  output wire        zero_o,
  output wire [12:0] exp_o
);
  wire [10:0] efld;   // biased exponent field
  wire        fnz;    // fraction non-zero

  assign efld   = val_i[62:52];
  assign fnz    = |val_i[51:0];
  assign sign_o = val_i[63];
  // all-ones exponent marks infinity or NaN
  assign nan_o  = (efld == 11'h7FF) & fnz;
  // quiet bit clear means signaling
  assign snan_o = nan_o & ~val_i[51];
  assign inf_o  = (efld == 11'h7FF) & ~fnz;
  assign zero_o = (efld == 11'h000) & ~fnz;
  // unbiased exponent
  assign exp_o  = {2'b00, efld} - `FPX_BIAS;
endmodule // fpx_opclass
`default_nettype wire

// file: fpx_exc_checker.sv
// port assertions for the floating-point exception condition unit
`timescale 1ns/1ps
`default_nettype none
`include "fpx_map.vh"
module fpx_exc_checker (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        op_valid_i,
  input wire logic [3:0]  op_kind_i,
  input wire logic [63:0] op_a_i,
  input wire logic [63:0] op_b_i,
  input wire logic        sw_wr_i,
  input wire logic        sw_setbit_i,
  input wire logic [31:0] float_status_control_reg_o,
  input wire logic        dest_wr_o,
  input wire logic [63:0] dest_float_reg_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // helpers: operation without software write in the same cycle
  wire        q     = op_valid_i && !sw_wr_i && !sw_setbit_i;
  wire [31:0] st    = float_status_control_reg_o;
  // finite non-zero dividend over a zero divisor
  wire        zdiv  = q && op_kind_i == `FPX_OP_DIV && op_b_i[62:0] == 63'h0 &&
                      op_a_i[62:52] != 11'h7FF && op_a_i[62:0] != 63'h0;
  wire        zsign = op_a_i[63] ^ op_b_i[63];  // sign of the infinite result
  wire        a_nan = op_a_i[62:52] == 11'h7FF && op_a_i[51:0] != 52'h0;
  // any condition flag standing with its trap enable: VX/VE OX/OE UX/UE ZX/ZE XX/XE
  wire        en_hit = (st[29] & st[7]) | (st[28] & st[6]) | (st[27] & st[5]) |
                       (st[26] & st[4]) | (st[25] & st[3]);
  ////////////////////////////////////////////////////////////////////////////
  chk_dest_cause: assert property (dest_wr_o |-> $past(op_valid_i))
    else $error("destination written without an operation");
  chk_move_quiet: assert property (q && op_kind_i == `FPX_OP_MOVE
    |=> !dest_wr_o && $stable(float_status_control_reg_o))
    else $error("move operation changed state");
  chk_zdiv_off: assert property (zdiv && !st[4] |=> dest_wr_o && st[26] &&
    dest_float_reg_o == {$past(zsign), 63'h7FF0_0000_0000_0000})
    else $error("disabled zero divide result wrong");
  chk_zdiv_on: assert property (zdiv && st[4]
    |=> !dest_wr_o && st[26] && $stable(dest_float_reg_o))
    else $error("enabled zero divide touched destination");
  chk_sticky_flags: assert property (!sw_wr_i
    |=> ($past(st) & `FPX_EXC_MASK & ~st) == 32'h0000_0000)
    else $error("condition flag fell without software write");
  chk_fx_rise: assert property (
    (st & ~$past(st) & `FPX_EXC_MASK) != 32'h0000_0000 |-> st[31])
    else $error("summary not set on flag rise");
  chk_fex_sum: assert property (en_hit |-> st[30])
    else $error("enabled summary missing");
  chk_inv_cmp: assert property (q && op_kind_i == `FPX_OP_CMPO && a_nan
    |=> st[15:12] == `FPX_CC_UNORD && st[19] && !dest_wr_o &&
        st[18:16] == $past(st[18:16]))
    else $error("ordered compare with nan wrong");
  chk_vx_sum: assert property (st[29] == |(st & `FPX_INV_MASK))
    else $error("invalid summary disagrees with causes");
  // main scenarios reached
  cov_zdiv: cover property (zdiv ##1 dest_wr_o);
  cov_ovf: cover property (st[28]);
  cov_unf: cover property (st[27]);
endmodule // fpx_exc_checker
bind fpx_exc_unit fpx_exc_checker chk_i (.core_clk_i, .sys_rst_i, .op_valid_i, .op_kind_i,
  .op_a_i, .op_b_i, .sw_wr_i, .sw_setbit_i, .float_status_control_reg_o, .dest_wr_o,
  .dest_float_reg_o);
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the exception condition unit
`timescale 1ns/1ps
`default_nettype none
`include "fpx_map.vh"
module tb_top;
  localparam logic [63:0] ONE  = 64'h3FF0_0000_0000_0000;  // +1.0
  localparam logic [63:0] MONE = 64'hBFF0_0000_0000_0000;  // -1.0
  localparam logic [63:0] INF  = 64'h7FF0_0000_0000_0000;  // +infinity
  localparam logic [63:0] SNAN = 64'h7FF4_0000_0000_0000;  // signaling nan
  localparam logic [63:0] MAXF = 64'h7FEF_FFFF_FFFF_FFFF;  // largest finite
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        op_valid_i = 1'b0, single_prec_i = 1'b0, pre_zero_i = 1'b0;
  logic [3:0]  op_kind_i = 4'h0, cmp_code_i = 4'h2;
  logic [63:0] op_a_i = 64'h0, op_b_i = 64'h0, op_c_i = 64'h0;
  logic [12:0] pre_exp_i = 13'h0, rnd_exp_i = 13'h0;
  logic        rnd_sign_i = 1'b0, rnd_up_i = 1'b0, rnd_inexact_i = 1'b0;
  logic [51:0] rnd_frac_i = 52'h0;
  logic [63:0] den_result_i = 64'h0, int_result_i = 64'h0;
  logic        den_up_i = 1'b0, den_inexact_i = 1'b0, int_inexact_i = 1'b0;
  logic        sw_wr_i = 1'b0, sw_setbit_i = 1'b0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic [4:0]  sw_bit_i = 5'h0;
  wire  [31:0] float_status_control_reg_o;
  wire         dest_wr_o;
  wire  [63:0] dest_float_reg_o;
  wire  [31:0] st = float_status_control_reg_o;  // status shorthand
  int          n_errors = 0, n_checks = 0;
  // invalid-cause table: op, operands, flag bit
  logic [3:0]  iv_k [5] = '{`FPX_OP_ADD, `FPX_OP_DIV, `FPX_OP_MUL, `FPX_OP_SQRT, `FPX_OP_CVT64};
  logic [63:0] iv_a [5] = '{INF, INF, INF, 64'h0, 64'h0};
  logic [63:0] iv_b [5] = '{{1'b1, INF[62:0]}, INF, ONE, MONE, INF};
  int          iv_bit [5] = '{23, 22, 20, 9, 8};
  fpx_exc_unit uut (.core_clk_i, .sys_rst_i, .op_valid_i, .op_kind_i, .single_prec_i,
    .op_a_i, .op_b_i, .op_c_i, .cmp_code_i, .pre_zero_i, .pre_exp_i, .rnd_sign_i,
    .rnd_exp_i, .rnd_frac_i, .rnd_up_i, .rnd_inexact_i, .den_result_i, .den_up_i,
    .den_inexact_i, .int_result_i, .int_inexact_i, .sw_wr_i, .sw_wdata_i, .sw_setbit_i,
    .sw_bit_i, .float_status_control_reg_o, .dest_wr_o, .dest_float_reg_o);
  always #20 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and stop
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle status write (set=0) or single bit set (set=1)
  task automatic sw(input logic set, input logic [31:0] d);
    @(negedge core_clk_i);
    sw_wdata_i = d;
    sw_bit_i = d[4:0];
    sw_wr_i = !set;
    sw_setbit_i = set;
    @(negedge core_clk_i);
    sw_wr_i = 1'b0;
    sw_setbit_i = 1'b0;
  endtask
  // one-cycle operation; outputs settle by the following falling edge
  task automatic op(input logic [3:0] k, input logic [63:0] a, b, input logic [12:0] e);
    @(negedge core_clk_i);
    op_kind_i = k;
    op_a_i = a;
    op_b_i = b;
    pre_exp_i = e;
    rnd_exp_i = e;
    op_valid_i = 1'b1;
    @(negedge core_clk_i);
    op_valid_i = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // zero divide, both trap settings, and 0/0
  task automatic t_zdiv;
    op(`FPX_OP_DIV, ONE, 64'h8000_0000_0000_0000, 13'h0);
    chk("zd_dest", dest_float_reg_o, 64'hFFF0_0000_0000_0000);
    chk("zd_flags", {dest_wr_o, st[26], st[31], st[18:12]}, 10'h389);
    sw(0, 32'h0000_0010);
    op(`FPX_OP_DIV, ONE, 64'h0, 13'h0);
    chk("zde_flags", {dest_wr_o, st[26], st[30]}, 3'b011);
    chk("zde_dest", dest_float_reg_o, 64'hFFF0_0000_0000_0000);
    sw(0, 32'h0000_0010);
    op(`FPX_OP_DIV, 64'h0, 64'h0, 13'h0);
    chk("zz_dest", dest_float_reg_o, `FPX_QNAN);
    chk("zz_flags", {st[21], st[26], st[16:12]}, 7'h51);
  endtask
  // enabled invalid: signaling nan, then inf-inf, inf/inf, inf*zero, sqrt and convert causes
  task automatic t_inv;
    sw(0, 32'h0006_4080);
    op(`FPX_OP_ADD, SNAN, ONE, 13'h0);
    chk("snan_flag", st[`FPX_INV_SIGNALING_NAN_FLAG], 1'b1);
    chk("snan_kept", {dest_wr_o, st[18:12]}, 8'h04);
    chk("snan_dest", dest_float_reg_o, `FPX_QNAN);
    for (int i = 0; i < 5; i++) begin
      sw(0, 32'h0000_0080);
      op(iv_k[i], iv_a[i], iv_b[i], 13'h0);
      chk("inv_cause", st[iv_bit[i]], 1'b1);
      chk("inv_flags", {dest_wr_o, st[`FPX_VX], st[31]}, 3'b011);
    end
  endtask
  // ordered and unordered compare on a quiet nan
  task automatic t_cmp;
    sw(0, 32'h0007_0000);
    op(`FPX_OP_CMPO, `FPX_QNAN, ONE, 13'h0);
    chk("cmpo_code", st[18:12], 7'h71);
    chk("cmpo_flag", st[`FPX_INV_COMPARE_FLAG], 1'b1);
    sw(0, 32'h0);
    op(`FPX_OP_CMPU, `FPX_QNAN, ONE, 13'h0);
    chk("cmpu_code", {st[`FPX_INV_COMPARE_FLAG], st[15:12]}, 5'h01);
    op(`FPX_OP_CMPU, ONE, ONE, 13'h0);
    chk("cmp_ordered", {st[`FPX_INV_COMPARE_FLAG], st[15:12]}, 5'h02);
  endtask
  // software request, stickiness and clearing
  task automatic t_soft;
    sw(0, 32'h0006_4000);
    sw(1, 32'h0000_000A);
    chk("soft_flag", {st[31], st[`FPX_VX], st[`FPX_INV_SOFTWARE_REQUEST_FLAG]}, 3'b111);
    chk("soft_keep", st[18:12], 7'h64);
    op(`FPX_OP_MOVE, SNAN, SNAN, 13'h0);
    chk("move_quiet", {dest_wr_o, st[`FPX_INV_SOFTWARE_REQUEST_FLAG], st[`FPX_INV_SIGNALING_NAN_FLAG]}, 3'b010);
    sw(0, 32'h0);
    chk("sw_clear", st, 32'h0);
  endtask
  // integer converts: invalid 32 and 64 bit, then a valid inexact one
  task automatic t_cvt;
    sw(0, 32'h0006_0000);
    op(`FPX_OP_CVT32, 64'h0, `FPX_QNAN, 13'h0);
    chk("cvt32_low", dest_float_reg_o[31:0], 32'h8000_0000);
    chk("cvt32_flag", {dest_wr_o, st[`FPX_INV_INT_CONVERT_FLAG], st[18:17]}, 4'hC);
    op(`FPX_OP_CVT64, 64'h0, INF, 13'h0);
    chk("cvt64_dest", dest_float_reg_o, `FPX_INT64_MN);
    int_result_i = 64'h0000_0000_0000_0007;
    int_inexact_i = 1'b1;
    sw(0, 32'h0);
    op(`FPX_OP_CVT64, 64'h0, 64'h401C_0000_0000_0000, 13'h0);
    chk("cvt_ok", {st[`FPX_INV_INT_CONVERT_FLAG], st[`FPX_XX], st[18:17]}, 4'h5);
    chk("cvt_dest", dest_float_reg_o, 64'h0000_0000_0000_0007);
  endtask
  // overflow in every rounding mode and both signs, then trapped
  task automatic t_ovf;
    logic [63:0] mag;
    for (int i = 0; i < 8; i++) begin
      rnd_sign_i = i[2];
      sw(0, {30'h0, i[1:0]});
      op(`FPX_OP_ADD, ONE, ONE, 13'h0400);
      mag = (i[1:0] == 2'd0 || i[1:0] == {1'b1, i[2]}) ? INF : MAXF;
      chk("ovf_dest", dest_float_reg_o, {i[2], mag[62:0]});
      chk("ovf_flag", {st[`FPX_OX], st[`FPX_XX], st[18:17]}, 4'hC);
    end
    rnd_sign_i = 1'b0;
    rnd_frac_i = 52'h8_0000_0000_0000;
    sw(0, 32'h0000_0040);
    op(`FPX_OP_ADD, ONE, ONE, 13'h0400);
    chk("ovf_trap", dest_float_reg_o, 64'h1FF8_0000_0000_0000);
    chk("ovf_cls", {st[`FPX_OX], st[16:12]}, 6'h24);
    single_prec_i = 1'b1;
    sw(0, 32'h0000_0001);
    op(`FPX_OP_ADD, ONE, ONE, 13'h0080);
    chk("ovf_single", dest_float_reg_o, 64'h47EF_FFFF_E000_0000);
    single_prec_i = 1'b0;
  endtask
  // underflow trapped, denormalized, exact; then plain inexact
  task automatic t_unf;
    rnd_up_i = 1'b1;
    rnd_inexact_i = 1'b1;
    sw(0, 32'h0000_0020);
    op(`FPX_OP_ADD, ONE, MONE, 13'h1C01);
    chk("unf_trap", dest_float_reg_o, 64'h6008_0000_0000_0000);
    chk("unf_round", {st[`FPX_UX], st[18:17]}, 3'h7);
    rnd_up_i = 1'b0;
    den_result_i = 64'h0008_0000_0000_0000;
    den_inexact_i = 1'b1;
    sw(0, 32'h0);
    op(`FPX_OP_ADD, ONE, MONE, 13'h1C01);
    chk("unf_dest", dest_float_reg_o, 64'h0008_0000_0000_0000);
    chk("unf_cls", {st[`FPX_UX], st[16:12]}, 6'h34);
    den_inexact_i = 1'b0;
    rnd_inexact_i = 1'b0;
    sw(0, 32'h0);
    op(`FPX_OP_ADD, ONE, MONE, 13'h1C01);
    chk("unf_exact", st[`FPX_UX], 1'b0);
    rnd_inexact_i = 1'b1;
    sw(0, 32'h0000_0008);
    op(`FPX_OP_ADD, ONE, ONE, 13'h0);
    chk("inx_flag", {st[`FPX_XX], st[18:12]}, 8'hA4);
    chk("inx_dest", dest_float_reg_o, 64'h3FF8_0000_0000_0000);
    chk("inx_fex", st[30], 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk("reset_status", {dest_wr_o, st}, 33'h0);
    t_zdiv();
    t_inv();
    t_cmp();
    t_soft();
    t_cvt();
    t_ovf();
    t_unf();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
